// [fpcmd_pkg.sv]
// Purpose: Shared constants and carriers for the float command handler.
// Assumes: Command word 8 bits used, float values as raw 32-bit words.
// Notes: Type codes and command codes are named here once.
`default_nettype none
package fpcmd_pkg;
  localparam logic [7:0] CMD_ROTATE = 8'h00;
  localparam logic [7:0] CMD_CUR = 8'h01;
  localparam logic [7:0] CMD_NEXT = 8'h02;
  localparam logic [7:0] CMD_CLR_ROT = 8'h03;
  localparam logic [7:0] CMD_NET = 8'h0b;
  localparam logic [7:0] CMD_ROT_LO = 8'h28;
  localparam logic [7:0] CMD_ROT_HI = 8'h30;
  localparam logic [7:0] CMD_MSG_CLR = 8'h50;
  localparam logic [7:0] CMD_MSG_LO = 8'h51;
  localparam logic [7:0] CMD_MSG_PROMPT = 8'h56;
  localparam logic [7:0] CMD_MSG_HI = 8'h57;
  localparam logic [7:0] CMD_TARGET = 8'h6e;
  localparam logic [7:0] CMD_CMP_START = 8'h72;
  localparam logic [7:0] CMD_APPLY = 8'ha0;
  localparam logic [7:0] CMD_FILL_LO = 8'haa;
  localparam logic [7:0] CMD_FILL_SET_HI = 8'hb3;
  localparam logic [7:0] CMD_FILL_HI = 8'hc7;
  localparam logic [7:0] TYPE_GROSS = 8'h00;
  localparam logic [7:0] TYPE_NET = 8'h01;
  localparam logic [7:0] TYPE_NONE = 8'h1e;
  localparam logic [31:0] FLOAT_ZERO = 32'h0000_0000;
  localparam logic [1:0] ACK_IDLE = 2'h0;
  localparam logic [1:0] ACK_LAST = 2'h3;
  localparam int MSG_MAX_CHARS = 20;
  localparam int ROT_SLOTS = 9;
  // Interface update period in microseconds and in clock cycles.
  localparam int UPDATE_US = 60000;
  localparam int CLK_MHZ = 100;
  localparam int UPDATE_CYCLES = UPDATE_US * CLK_MHZ;

  typedef struct packed {
    logic [1:0] ack;
    logic [7:0] type_code;
    logic [31:0] value;
  } reply_t;

  typedef struct packed {
    logic [3:0] index;
    logic [7:0] cmd;
    logic [31:0] operand;
  } word_t;
endpackage
`default_nettype wire

// [fpcmd_fifo.sv]
// Purpose: Keeps the reply queue's place among the source files.
// Assumes: The reply FIFO module sits beside the handler, in one file.
// Notes: Holds no logic, so that one design file carries all of it.

// [fpcmd_handler.sv]
// Purpose: Floating-point command interpreter of a weighing terminal.
// Assumes: Weights and stored values arrive as raw float words on clk.
// Notes: Replies are queued in a FIFO; the bus side drains it.
// Operation
// RL1: Commands 40..48 build the report rotation.
// RL2: Every value carries its type code.
// RL3: Controller samples outputs every 30 ms or faster.
// RL4: Command 0 without rotation reports gross.
// RL5: Acknowledge stays 0 while rotating.
// RL6: Refresh commands update every cycle while held.
// RL7: Toggling 1 and 2 steps the rotation.
// RL8: String fields return first four characters.
// RL9: Specific request reports only that value.
// RL10: Controller places operand before load command.
// RL11: Successful load echoes the operand.
// RL12: Action commands return float zero.
// RL13: Messages above prompts, at most 20 characters.
// RL14: Commands 80..87 drive message display and codes.
// RL15: Command 160 applies changed setup classes.
// RL16: Fill commands need the filling option.
// RL17: Without option, fill commands reach shared fields; only 170..179 do here.
// RL18: Target load 110 echoes, 114 returns zero.
// RL19: New commands cycle acknowledge 1,2,3; type 30.
// RL20: Controller waits for acknowledge before next command.
// RL21: Command 3 clears the rotation.
// RL22: Command 0 rotates one field per update.
// RL23: Command 11 refreshes net, ack 1, type 1.
// RL24: Only a changed command word is new.
`default_nettype none
module fpcmd_handler #(
  parameter int UPDATE_CYCLES = fpcmd_pkg::UPDATE_CYCLES,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] cmd_word,
  input wire logic [31:0] cmd_operand,
  input wire logic fill_option_present,
  input wire logic [31:0] gross_value,
  input wire logic [31:0] net_value,
  input wire logic [31:0] tare_value,
  input wire logic [31:0] fine_gross_value,
  input wire logic [31:0] fine_net_value,
  input wire logic [31:0] fine_tare_value,
  input wire logic [31:0] rate_value,
  input wire logic [31:0] custom_string_one,
  input wire logic [31:0] custom_string_two,
  output fpcmd_pkg::reply_t reply,
  output logic reply_valid,
  input wire logic reply_ready,
  output logic [3:0] message_select,
  output logic [7:0] message_event_code,
  output logic prompt_start_flag,
  output logic [4:0] message_max_chars,
  output logic setup_apply,
  output logic [31:0] target_value,
  output logic target_compare_start,
  output logic fill_write,
  output logic fill_shared_write,
  output logic [7:0] fill_index,
  output logic [31:0] fill_data
);
  // Checked while the design is built, so a bad period never runs.
  if (UPDATE_CYCLES < 1) begin : gen_bad_period
    $error("update period must be at least one cycle");
  end

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_ROT = 2'b01,
    MODE_SINGLE = 2'b10,
    MODE_FIXED = 2'b11
  } mode_t;

  typedef struct packed {
    logic [7:0] cmd_s1;
    logic [7:0] cmd_s2;
    logic [7:0] cmd_s3;
    logic [31:0] op_s1;
    logic [31:0] op_s2;
    logic [7:0] cmd_last;
    logic seen;
    logic [8:0] rot_mask;
    logic [3:0] rot_order;
    logic [3:0] rot_pos;
    logic [1:0] ack;
    mode_t mode;
    logic [7:0] src;
    logic [31:0] fixed;
    logic [31:0] tick;
    logic [3:0] msg;
    logic [7:0] evt;
    logic prompt;
    logic apply;
    logic [31:0] target;
    logic cmp;
    logic fw;
    logic fsw;
    logic [7:0] fidx;
    logic [31:0] fdat;
  } state_t;

  state_t s_q;
  state_t s_d;
  fpcmd_pkg::reply_t push_data;
  logic push_valid;
  logic push_ready;

  // Source selector: codes 0..8 follow the rotation-add order.
  function automatic fpcmd_pkg::reply_t pick(input logic [7:0] code,
                                             input logic [1:0] ack);
    fpcmd_pkg::reply_t r;
    r.ack = ack;
    r.type_code = code; // [RL2]
    case (code)
      8'h00: r.value = gross_value;
      8'h01: r.value = net_value;
      8'h02: r.value = tare_value;
      8'h03: r.value = fine_gross_value;
      8'h04: r.value = fine_net_value;
      8'h05: r.value = fine_tare_value;
      8'h06: r.value = rate_value;
      8'h07: r.value = custom_string_one; // [RL8]
      default: r.value = custom_string_two; // [RL8]
    endcase
    return r;
  endfunction

  // Next configured slot after pos, wrapping round.
  function automatic logic [3:0] next_slot(input logic [8:0] mask,
                                           input logic [3:0] pos);
    logic [3:0] p;
    p = pos;
    for (int i = 0; i < fpcmd_pkg::ROT_SLOTS; i++) begin
      p = (p >= 4'(fpcmd_pkg::ROT_SLOTS - 1)) ? 4'h0 : p + 4'h1;
      if (mask[p]) begin
        return p;
      end
    end
    return pos;
  endfunction

  function automatic logic [1:0] bump(input logic [1:0] a);
    return (a == fpcmd_pkg::ACK_LAST) ? 2'h1 : a + 2'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic tick_now;
  logic is_new;
  assign tick_now = s_q.tick == 32'(UPDATE_CYCLES - 1);
  // The command word crosses bit by bit, so a word is only taken once two
  // synchronised samples agree; a torn word would otherwise fire a command.
  // Only a changed command word counts; seen catches the first one.
  assign is_new = (s_q.cmd_s2 == s_q.cmd_s3)
                  && (!s_q.seen || s_q.cmd_s3 != s_q.cmd_last); // [RL24]

  always_comb begin
    logic [7:0] c;
    logic [3:0] nx;
    s_d = s_q;
    c = s_q.cmd_s3;
    nx = 4'h0;
    s_d.cmd_s1 = cmd_word;
    s_d.cmd_s2 = s_q.cmd_s1;
    s_d.cmd_s3 = s_q.cmd_s2;
    s_d.op_s1 = cmd_operand;
    s_d.op_s2 = s_q.op_s1;
    s_d.tick = tick_now ? 32'h0 : s_q.tick + 32'h1;
    s_d.apply = 1'b0;
    s_d.cmp = 1'b0;
    s_d.fw = 1'b0;
    s_d.fsw = 1'b0;
    push_valid = 1'b0;
    push_data = pick(s_q.src, s_q.ack);
    if (is_new) begin
      s_d.seen = 1'b1;
      s_d.cmd_last = c;
      s_d.ack = bump(s_q.ack); // [RL19]
      s_d.mode = MODE_FIXED;
      s_d.src = fpcmd_pkg::TYPE_NONE; // [RL19]
      s_d.fixed = fpcmd_pkg::FLOAT_ZERO; // [RL12]
      if (c == fpcmd_pkg::CMD_ROTATE) begin
        s_d.ack = fpcmd_pkg::ACK_IDLE; // [RL5]
        s_d.mode = MODE_ROT;
        s_d.rot_pos = next_slot(s_q.rot_mask, 4'(fpcmd_pkg::ROT_SLOTS - 1));
        s_d.src = (s_q.rot_mask == 9'h0) ? fpcmd_pkg::TYPE_GROSS
                                          : 8'(s_d.rot_pos); // [RL4]
      end else if (c == fpcmd_pkg::CMD_CUR || c == fpcmd_pkg::CMD_NEXT) begin
        // Codes 1 and 2 alternate; a change between them steps once.
        s_d.mode = MODE_SINGLE;
        if ((s_q.cmd_last == fpcmd_pkg::CMD_CUR
             || s_q.cmd_last == fpcmd_pkg::CMD_NEXT) && s_q.seen) begin
          s_d.rot_order = next_slot(s_q.rot_mask, s_q.rot_order); // [RL7]
        end else begin
          s_d.rot_order = next_slot(s_q.rot_mask,
                                    4'(fpcmd_pkg::ROT_SLOTS - 1));
        end
        s_d.src = (s_q.rot_mask == 9'h0) ? fpcmd_pkg::TYPE_GROSS
                                          : 8'(s_d.rot_order);
      end else if (c == fpcmd_pkg::CMD_CLR_ROT) begin
        s_d.rot_mask = 9'h0; // [RL21]
      end else if (c >= fpcmd_pkg::CMD_ROT_LO
                   && c <= fpcmd_pkg::CMD_ROT_HI) begin
        s_d.rot_mask[4'(c - fpcmd_pkg::CMD_ROT_LO)] = 1'b1; // [RL1]
      end else if (c == fpcmd_pkg::CMD_NET) begin
        s_d.ack = 2'h1; // [RL23]
        s_d.mode = MODE_SINGLE; // [RL6] [RL9]
        s_d.src = fpcmd_pkg::TYPE_NET;
      end else if (c >= fpcmd_pkg::CMD_MSG_CLR
                   && c <= fpcmd_pkg::CMD_MSG_HI) begin
        s_d.msg = 4'(c - fpcmd_pkg::CMD_MSG_CLR); // [RL14]
        s_d.evt = c - fpcmd_pkg::CMD_MSG_CLR; // [RL14]
        if (c == fpcmd_pkg::CMD_MSG_PROMPT) begin
          s_d.prompt = 1'b1; // [RL14]
        end
      end else if (c == fpcmd_pkg::CMD_TARGET) begin
        s_d.target = s_q.op_s2; // [RL18]
        s_d.fixed = s_q.op_s2; // [RL11] [RL10]
      end else if (c == fpcmd_pkg::CMD_CMP_START) begin
        s_d.cmp = 1'b1; // [RL18]
      end else if (c == fpcmd_pkg::CMD_APPLY) begin
        s_d.apply = 1'b1; // [RL15]
      end else if (c >= fpcmd_pkg::CMD_FILL_LO
                   && c <= fpcmd_pkg::CMD_FILL_HI) begin
        s_d.fidx = c;
        s_d.fdat = s_q.op_s2;
        if (fill_option_present) begin
          s_d.fw = 1'b1; // [RL16]
          if (c <= fpcmd_pkg::CMD_FILL_SET_HI) begin
            s_d.fixed = s_q.op_s2; // [RL11]
          end
        end else if (c <= fpcmd_pkg::CMD_FILL_SET_HI) begin
          s_d.fsw = 1'b1; // [RL17]
          s_d.fixed = s_q.op_s2;
        end
      end
    end else if (tick_now) begin
      // An update that meets a newly taken command is skipped; the next
      // one already carries the new answer, so nothing stale goes out.
      // Each update refreshes the held answer; rotation also steps.
      push_valid = 1'b1; // [RL6]
      if (s_q.mode == MODE_ROT && s_q.rot_mask != 9'h0) begin
        nx = next_slot(s_q.rot_mask, s_q.rot_pos);
        s_d.rot_pos = nx; // [RL22]
        s_d.src = 8'(nx);
      end
      if (s_q.mode == MODE_FIXED || s_q.mode == MODE_NONE) begin
        push_data.type_code = fpcmd_pkg::TYPE_NONE;
        push_data.value = s_q.fixed;
      end
    end
    if (c != fpcmd_pkg::CMD_MSG_PROMPT && is_new) begin
      s_d.prompt = 1'b0;
    end
    // Replies refused when the queue is full are dropped; next update
    // carries fresher data, so no stall of the interpreter is needed.
    if (!push_ready) begin
      push_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  fpcmd_fifo #(
    .WIDTH($bits(fpcmd_pkg::reply_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(push_data),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(reply),
    .out_valid(reply_valid),
    .out_ready(reply_ready)
  );

  assign message_select = s_q.msg;
  assign message_event_code = s_q.evt;
  assign prompt_start_flag = s_q.prompt;
  assign message_max_chars = 5'(fpcmd_pkg::MSG_MAX_CHARS); // [RL13]
  assign setup_apply = s_q.apply;
  assign target_value = s_q.target;
  assign target_compare_start = s_q.cmp;
  assign fill_write = s_q.fw;
  assign fill_shared_write = s_q.fsw;
  assign fill_index = s_q.fidx;
  assign fill_data = s_q.fdat;
endmodule

////////////////////////////////////////////////////////////////////////
// Reply queue: flip-flop storage addressed by pointer, one clock.
// Pointers carry one extra bit, so full and empty are told apart
// without a separate count; the depth must be a power of two for that.
module fpcmd_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gen_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.wr - s_q.rd) != (AW + 1)'(DEPTH);
  assign out_valid = s_q.wr != s_q.rd;
  assign out_data = s_q.mem[s_q.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr[AW-1:0]] = in_data;
      s_d.wr = s_q.wr + (AW + 1)'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + (AW + 1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// [fpcmd_checker.sv]
// Purpose: Port checks for the float command handler.
// Assumes: The controller holds each command until it is answered.
// Notes: Causes sit two cycles back, behind the input synchroniser.
`default_nettype none
module fpcmd_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] cmd_word,
  input wire logic [31:0] cmd_operand,
  input wire logic fill_option_present,
  input wire logic [3:0] message_select,
  input wire logic [7:0] message_event_code,
  input wire logic prompt_start_flag,
  input wire logic [4:0] message_max_chars,
  input wire logic setup_apply,
  input wire logic [31:0] target_value,
  input wire logic target_compare_start,
  input wire logic fill_write,
  input wire logic fill_shared_write
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_msg_width:
    assert property (message_max_chars == 5'h14)
    else $error("message width limit wrong");
  a_apply_cause:
    assert property (setup_apply |-> $past(cmd_word, 2) == 8'ha0)
    else $error("apply pulse without apply command");
  a_apply_due:
    assert property ($changed(cmd_word) && cmd_word == 8'ha0
      |-> ##[1:6] setup_apply)
    else $error("apply pulse missing");
  a_apply_once:
    assert property (setup_apply |=> !setup_apply [*8])
    else $error("held apply command fired again");
  a_cmp_cause:
    assert property (target_compare_start |-> $past(cmd_word, 2) == 8'h72)
    else $error("compare start without its command");
  a_target_echo:
    assert property ($changed(cmd_word) && cmd_word == 8'h6e
      |-> ##[1:6] target_value == cmd_operand)
    else $error("target not loaded from operand");
  a_fill_option:
    assert property (fill_write |-> fill_option_present
      && $past(cmd_word, 2) inside {[8'haa:8'hc7]})
    else $error("fill write without option");
  a_fill_shared:
    assert property (fill_shared_write |-> !fill_option_present
      && $past(cmd_word, 2) inside {[8'haa:8'hb3]})
    else $error("shared write outside set range");
  a_msg_code:
    assert property ($changed(cmd_word) && cmd_word inside {[8'h51:8'h57]}
      |-> ##[1:6] message_event_code == cmd_word - 8'h50
      && message_select == 4'(cmd_word - 8'h50))
    else $error("message code or select wrong");
  a_msg_clear:
    assert property ($changed(cmd_word) && cmd_word == 8'h50
      |-> ##[1:6] message_select == 4'h0)
    else $error("message not cleared");
  a_prompt_cause:
    assert property ($rose(prompt_start_flag)
      |-> $past(cmd_word, 2) == 8'h56)
    else $error("prompt flag without prompt command");
  cover property (setup_apply);
  cover property (fill_shared_write);
  cover property ($rose(prompt_start_flag));
  cover property (target_compare_start);
endmodule
////////////////////////////////////////
bind fpcmd_handler fpcmd_checker fpcmd_checker_inst (.clk, .rst_b,
  .cmd_word, .cmd_operand, .fill_option_present, .message_select,
  .message_event_code, .prompt_start_flag, .message_max_chars,
  .setup_apply, .target_value, .target_compare_start, .fill_write,
  .fill_shared_write);
`default_nettype wire

// [fpcmd_plc_model.sv]
// Purpose: Controller model that issues commands and drains replies.
// Assumes: One command at a time, held until it is answered.
// Notes: Random drain pacing stands for a slow or a quick scan.
`default_nettype none
module fpcmd_plc_model (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire fpcmd_pkg::reply_t reply,
  input wire logic reply_valid,
  output logic reply_ready,
  output logic [7:0] cmd_word,
  output logic [31:0] cmd_operand
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 25;
  int got = 0;
  fpcmd_pkg::reply_t last;
  initial begin
    cmd_word = 8'h00;
    cmd_operand = 32'h0000_0000;
    reply_ready = 1'b0;
  end
  // Mode 0 drains at random, 1 stalls, 2 drains every cycle.
  always @(posedge clk) begin
    if (reply_valid && reply_ready) begin
      last <= reply;
      got <= got + 1;
    end
    reply_ready <= #1 mode == 2'h2 ||
      (mode == 2'h0 && $random(seed) % 2 != 0);
  end
  task automatic wait_replies(input int n);
    int g0;
    g0 = got;
    for (int i = 0; i < 100 * n && got < g0 + n; i++) @(posedge clk);
    #1;
  endtask
  // The operand goes out a cycle early so a load never sees it moving.
  task automatic send(input logic [7:0] c, input logic [31:0] op);
    @(posedge clk);
    #1 cmd_operand = op;
    @(posedge clk);
    #1 cmd_word = c;
    wait_replies(3);
  endtask
endmodule
`default_nettype wire

// [fpcmd_handler_tb_top.sv]
// Purpose: Self-checking bench for the float command handler.
// Assumes: Update tick shortened to 20 cycles.
// Notes: Replies are judged on the third reply after each command.
`default_nettype none
`define CHK(what, exp, seen) \
  begin \
    tests_run++; \
    if ((seen) !== (exp)) begin \
      num_errors++; \
      $display("Error %s exp %0h seen %0h", what, exp, seen); \
    end \
  end
module fpcmd_handler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic fill_option_present = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [31:0] src [9];
  logic [7:0] rot [3] = '{8'h28, 8'h2e, 8'h2f};
  logic [7:0] cmd_word, message_event_code, t;
  logic [31:0] cmd_operand, target_value, fill_data, op;
  logic reply_valid, reply_ready, prompt_start_flag;
  logic fill_write, fill_shared_write;
  logic setup_apply, target_compare_start;
  logic [7:0] fill_index;
  logic [3:0] message_select;
  logic [4:0] message_max_chars;
  fpcmd_pkg::reply_t reply, last;
  int seed = 25;
  int num_errors = 0;
  int tests_run = 0;
  int n_fill = 0;
  int n_shared = 0;
  int n_apply = 0;
  int n_cmp = 0;
  int n;
  fpcmd_handler #(.UPDATE_CYCLES(20), .FIFO_DEPTH(32)) fpcmd_handler_inst (
    .clk, .rst_b, .cmd_word, .cmd_operand, .fill_option_present,
    .gross_value(src[0]), .net_value(src[1]), .tare_value(src[2]),
    .fine_gross_value(src[3]), .fine_net_value(src[4]),
    .fine_tare_value(src[5]), .rate_value(src[6]),
    .custom_string_one(src[7]), .custom_string_two(src[8]),
    .reply, .reply_valid, .reply_ready, .message_select,
    .message_event_code, .prompt_start_flag, .message_max_chars,
    .setup_apply, .target_value, .target_compare_start,
    .fill_write, .fill_shared_write, .fill_index, .fill_data);
  fpcmd_plc_model fpcmd_plc_model_inst (.clk, .mode, .reply,
    .reply_valid, .reply_ready, .cmd_word, .cmd_operand);
  assign last = fpcmd_plc_model_inst.last;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (fill_write) n_fill <= n_fill + 1;
    if (fill_shared_write) n_shared <= n_shared + 1;
    if (setup_apply) n_apply <= n_apply + 1;
    if (target_compare_start) n_cmp <= n_cmp + 1;
  end
  ////////////////////////////////////////
  function automatic logic [1:0] next_ack(input logic [1:0] a);
    return (a == 2'h3) ? 2'h1 : a + 2'h1;
  endfunction
  // Rotation visits the added codes in ascending order, wrapping round.
  function automatic logic [7:0] next_slot(input logic [8:0] m,
    input logic [7:0] s);
    for (int i = 1; i <= 9; i++) begin
      if (m[(int'(s) + i) % 9]) return 8'((int'(s) + i) % 9);
    end
    return s;
  endfunction
  task automatic go(input logic [7:0] c, input logic [31:0] v);
    fpcmd_plc_model_inst.send(c, v);
  endtask
  task automatic chk_reply(input logic [1:0] a, input logic [7:0] ty,
    input logic [31:0] v);
    `CHK("ack", a, last.ack)
    `CHK("type", ty, last.type_code)
    `CHK("value", v, last.value)
  endtask
  // Command 0 steps one field per update; fresh samples catch stale data.
  task automatic rot_check(input logic [8:0] m, input int k);
    go(8'h00, 32'h0);
    for (int i = 0; i < k; i++) begin
      t = last.type_code;
      foreach (src[j]) src[j] = $random(seed);
      fpcmd_plc_model_inst.wait_replies(1);
      `CHK("slot", next_slot(m, t), last.type_code)
      `CHK("field", src[last.type_code[3:0]], last.value)
      `CHK("rot ack", 2'h0, last.ack)
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    logic [1:0] a;
    foreach (src[i]) src[i] = $random(seed);
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    a = 2'h0;
    fpcmd_plc_model_inst.wait_replies(3);
    chk_reply(a, 8'h00, src[0]);
    go(8'h0b, 32'h0);
    a = next_ack(a);
    chk_reply(a, 8'h01, src[1]);
    src[1] = $random(seed);
    fpcmd_plc_model_inst.wait_replies(2);
    chk_reply(a, 8'h01, src[1]);
    op = $random(seed);
    go(8'h6e, op);
    a = next_ack(a);
    chk_reply(a, 8'h1e, op);
    `CHK("target", op, target_value)
    go(8'h72, $random(seed));
    a = next_ack(a);
    chk_reply(a, 8'h1e, 32'h0);
    `CHK("compare", 1, n_cmp)
    go(8'h03, 32'h0);
    a = next_ack(a);
    chk_reply(a, 8'h1e, 32'h0);
    foreach (rot[i]) begin
      go(rot[i], $random(seed));
      a = next_ack(a);
      chk_reply(a, 8'h1e, 32'h0);
    end
    rot_check(9'h0c1, 6);
    go(8'h01, 32'h0);
    `CHK("first", 8'h00, last.type_code)
    fpcmd_plc_model_inst.wait_replies(2);
    `CHK("held", 8'h00, last.type_code)
    go(8'h02, 32'h0);
    `CHK("next", 8'h06, last.type_code)
    go(8'h01, 32'h0);
    `CHK("text", src[7], last.value)
    go(8'h03, 32'h0);
    for (int c = 8'h29; c <= 8'h30; c++) begin
      if (c < 8'h2e || c == 8'h30) go(8'(c), $random(seed));
    end
    rot_check(9'h13e, 8);
    for (int c = 8'h50; c <= 8'h57; c++) begin
      go(8'(c), 32'h0);
      `CHK("select", 4'(c - 8'h50), message_select)
      if (c > 8'h50) `CHK("code", 8'(c - 8'h50), message_event_code)
      if (c == 8'h56) `CHK("prompt", 1'b1, prompt_start_flag)
      `CHK("zero", 32'h0, last.value)
    end
    `CHK("width", 5'h14, message_max_chars)
    go(8'ha0, 32'h0);
    `CHK("apply", 1, n_apply)
    op = $random(seed);
    go(8'haa, op);
    `CHK("shared", 1, n_shared)
    `CHK("fill data", op, fill_data)
    fill_option_present = 1'b1;
    go(8'hab, op);
    `CHK("fill", 1, n_fill)
    `CHK("fill index", 8'hab, fill_index)
    `CHK("no shared", 1, n_shared)
    mode = 2'h1;
    repeat (700) @(posedge clk);
    #1 mode = 2'h2;
    n = fpcmd_plc_model_inst.got;
    for (int i = 0; i < 100 && reply_valid; i++) @(posedge clk);
    #1 n = fpcmd_plc_model_inst.got - n;
    `CHK("depth", 1'b1, n >= 32 && n <= 34)
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
